// ===== inc/usb_reset_scope_regs.svh
// Register offsets, field positions, reset values and timing figures of the USB reset scope.
// Assumes byte addresses on a 32-bit APB bus, one aligned word per register.
`ifndef USB_RESET_SCOPE_REGS_SVH
`define USB_RESET_SCOPE_REGS_SVH
`define CORE_BASE_OFS 12'h300
`define CORE_LAST_OFS 12'h33C
`define PCC_OFS 12'h3D8
`define SYNTH_OFS 12'h3DC
`define MODE0_OFS 12'h3E0
`define MODE1_OFS 12'h3E4
`define IRQ2_IDX 4'h1
`define FIFO_DATA_IDX 4'hE
`define FIFO_STAT_IDX 4'hF
`define RST_EVT_BIT 5
`define CORE_EN_BIT 7
`define CORE_RST_VAL 32'h0000_0000
`define PCC_RST_VAL 32'h0000_0000
`define SYNTH_RST_VAL 32'h0000_0000
`define MODE0_RST_VAL 32'h0000_0000
`define MODE1_RST_VAL 32'h0000_0000
`define SE0_MIN_NS 2500
`define CLK_PERIOD_NS 50
`endif

// ===== inc/usb_reset_scope_pkg.sv
// Types shared by the USB reset scope and its surroundings.
// Assumes an APB master with 12-bit byte addresses and 32-bit data.
package usb_reset_scope_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;
endpackage

// ===== verilog/usb_reset_scope_control.sv
// USB function core registers, FIFO pointers and clock registers with their reset scopes.
// Assumes one 20 MHz clock, an APB master on the same clock and D+/D- from pins.
`timescale 1ns/1ps
`default_nettype none
`include "usb_reset_scope_regs.svh"
module usb_reset_scope_control
   import usb_reset_scope_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic undef_opcode,
   input wire logic dp_pin,
   input wire logic dm_pin,
   input wire apb_req_t apb_req,
   output apb_rsp_t apb_rsp,
   output logic usb_func_irq,
   output logic usb_bus_reset
);
   localparam int PW = $clog2(FIFO_DEPTH);
   localparam int SE0_CYC = (`SE0_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam logic [6:0] SE0_LAST = 7'(SE0_CYC - 1);

   // Refuses depths that the pointer arithmetic and the status count field cannot serve.
   if (FIFO_DEPTH < 2 || FIFO_DEPTH > 64 || (1 << PW) != FIFO_DEPTH) begin : g_depth_check
      $error("FIFO_DEPTH must be a power of two from 2 to 64.");
   end

   logic [31:0] core_reg [16];
   logic [31:0] core_next [16];
   logic [31:0] pcc_reg, pcc_next, synth_reg, synth_next;
   logic [31:0] mode0_reg, mode0_next, mode1_reg, mode1_next;
   logic [PW:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
   logic [31:0] fifo_mem [FIFO_DEPTH];
   logic [6:0] se0_cnt_reg, se0_cnt_next;
   logic dp_meta_reg, dp_sync_reg, dm_meta_reg, dm_sync_reg;
   apb_rsp_t rsp_reg, rsp_next;
   logic irq_reg, irq_next, bus_rst_reg, bus_rst_next;
   logic hw_rst, se0, bus_det, access, done, is_core, mapped, push, pop, full, empty;
   logic [3:0] idx;
   logic [PW:0] count;
   logic [31:0] rdata;

   assign hw_rst = !rst_n || (ce && undef_opcode);
   assign se0 = !dp_sync_reg && !dm_sync_reg;
   assign bus_det = ce && se0 && pcc_reg[`CORE_EN_BIT] && se0_cnt_reg == SE0_LAST;
   assign access = apb_req.psel && apb_req.penable;
   assign done = ce && access && rsp_reg.pready;
   assign is_core = apb_req.paddr >= `CORE_BASE_OFS && apb_req.paddr <= `CORE_LAST_OFS;
   assign mapped = apb_req.paddr[1:0] == 2'h0 && (is_core || apb_req.paddr == `PCC_OFS
      || apb_req.paddr == `SYNTH_OFS || apb_req.paddr == `MODE0_OFS
      || apb_req.paddr == `MODE1_OFS);
   assign idx = apb_req.paddr[5:2];
   assign count = wr_ptr_reg - rd_ptr_reg;
   assign full = count == (PW + 1)'(FIFO_DEPTH);
   assign empty = count == '0;
   assign push = done && apb_req.pwrite && is_core && idx == `FIFO_DATA_IDX && !full;
   assign pop = done && !apb_req.pwrite && is_core && idx == `FIFO_DATA_IDX && !empty;

   always_comb begin
      rdata = 32'h0000_0000;
      if (is_core) begin
         if (idx == `FIFO_DATA_IDX) begin
            rdata = fifo_mem[rd_ptr_reg[PW-1:0]];
         end else if (idx == `FIFO_STAT_IDX) begin
            rdata = {16'h0000, 8'(count), 6'h00, full, empty};
         end else begin
            rdata = core_reg[idx];
         end
      end else if (apb_req.paddr == `PCC_OFS) begin
         rdata = pcc_reg;
      end else if (apb_req.paddr == `SYNTH_OFS) begin
         rdata = synth_reg;
      end else if (apb_req.paddr == `MODE0_OFS) begin
         rdata = mode0_reg;
      end else if (apb_req.paddr == `MODE1_OFS) begin
         rdata = mode1_reg;
      end
   end

   always_comb begin
      core_next = core_reg;
      pcc_next = pcc_reg;
      synth_next = synth_reg;
      mode0_next = mode0_reg;
      mode1_next = mode1_reg;
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      se0_cnt_next = se0_cnt_reg;
      rsp_next = rsp_reg;
      irq_next = irq_reg;
      bus_rst_next = bus_rst_reg;
      if (ce) begin
         irq_next = 1'b0;
         bus_rst_next = 1'b0;
         rsp_next.pready = access && !rsp_reg.pready;
         if (access && !rsp_reg.pready) begin
            rsp_next.prdata = apb_req.pwrite ? 32'h0000_0000 : (mapped ? rdata : 32'h0000_0000);
            rsp_next.pslverr = !mapped;
         end
         if (done && apb_req.pwrite && mapped) begin
            if (is_core && idx == `IRQ2_IDX) begin
               core_next[idx] = core_reg[idx] & ~apb_req.pwdata;
            end else if (is_core && idx != `FIFO_DATA_IDX && idx != `FIFO_STAT_IDX) begin
               core_next[idx] = apb_req.pwdata;
            end else if (apb_req.paddr == `PCC_OFS) begin
               pcc_next = apb_req.pwdata;
            end else if (apb_req.paddr == `SYNTH_OFS) begin
               synth_next = apb_req.pwdata;
            end else if (apb_req.paddr == `MODE0_OFS) begin
               mode0_next = apb_req.pwdata;
            end else if (apb_req.paddr == `MODE1_OFS) begin
               mode1_next = apb_req.pwdata;
            end
         end
         if (push) begin
            wr_ptr_next = wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_next = rd_ptr_reg + 1'b1;
         end
         if (!se0) begin
            se0_cnt_next = 7'h00;
         end else if (se0_cnt_reg != SE0_LAST + 7'h01) begin
            se0_cnt_next = se0_cnt_reg + 7'h01;
         end
         if (bus_det) begin
            for (int i = 0; i < 16; i++) begin
               core_next[i] = `CORE_RST_VAL;
            end
            core_next[`IRQ2_IDX][`RST_EVT_BIT] = 1'b1;
            wr_ptr_next = '0;
            rd_ptr_next = '0;
            irq_next = 1'b1;
            bus_rst_next = 1'b1;
         end
      end
      if (hw_rst) begin
         for (int i = 0; i < 16; i++) begin
            core_next[i] = `CORE_RST_VAL;
         end
         pcc_next = `PCC_RST_VAL;
         synth_next = `SYNTH_RST_VAL;
         mode0_next = `MODE0_RST_VAL;
         mode1_next = `MODE1_RST_VAL;
         wr_ptr_next = '0;
         rd_ptr_next = '0;
         se0_cnt_next = 7'h00;
         rsp_next = '0;
         irq_next = 1'b0;
         bus_rst_next = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dp_meta_reg <= 1'b1;
         dp_sync_reg <= 1'b1;
         dm_meta_reg <= 1'b1;
         dm_sync_reg <= 1'b1;
      end else if (ce) begin
         dp_meta_reg <= dp_pin;
         dp_sync_reg <= dp_meta_reg;
         dm_meta_reg <= dm_pin;
         dm_sync_reg <= dm_meta_reg;
      end
      core_reg <= core_next;
      pcc_reg <= pcc_next;
      synth_reg <= synth_next;
      mode0_reg <= mode0_next;
      mode1_reg <= mode1_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      se0_cnt_reg <= se0_cnt_next;
      rsp_reg <= rsp_next;
      irq_reg <= irq_next;
      bus_rst_reg <= bus_rst_next;
   end

   // Storage words have no reset of either kind; only pointers move.
   always_ff @(posedge clk) begin
      if (push && !hw_rst && !bus_det) begin
         fifo_mem[wr_ptr_reg[PW-1:0]] <= apb_req.pwdata;
      end
   end

   assign apb_rsp = rsp_reg;
   assign usb_func_irq = irq_reg;
   assign usb_bus_reset = bus_rst_reg;

   sequence s_bus_det;
      bus_det && !hw_rst;
   endsequence
   sequence s_core_clear;
      core_reg[0] == `CORE_RST_VAL && core_reg[2] == `CORE_RST_VAL;
   endsequence

   property p_hw_clear;
      @(posedge clk) disable iff (!rst_n) hw_rst |=> pcc_reg == `PCC_RST_VAL
         && synth_reg == `SYNTH_RST_VAL && core_reg[`IRQ2_IDX] == `CORE_RST_VAL && empty;
   endproperty
   a_hw_clear: assert property (p_hw_clear) else $error("Hardware reset left a register set.");
   property p_hw_wins;
      @(posedge clk) disable iff (!rst_n) bus_det && hw_rst |=> !core_reg[`IRQ2_IDX][`RST_EVT_BIT]
         && !usb_func_irq;
   endproperty
   a_hw_wins: assert property (p_hw_wins) else $error("Bus reset beat hardware reset.");
   property p_core_clear;
      @(posedge clk) disable iff (!rst_n) s_bus_det |=> s_core_clear;
   endproperty
   a_core_clear: assert property (p_core_clear) else $error("Core register kept after bus reset.");
   property p_evt_flag;
      @(posedge clk) disable iff (!rst_n) s_bus_det
         |=> core_reg[`IRQ2_IDX] == (32'h0000_0001 << `RST_EVT_BIT);
   endproperty
   a_evt_flag: assert property (p_evt_flag) else $error("Reset event flag not alone and set.");
   property p_fifo_empty;
      @(posedge clk) disable iff (!rst_n) s_bus_det |=> empty && wr_ptr_reg == '0;
   endproperty
   a_fifo_empty: assert property (p_fifo_empty) else $error("FIFO not empty after bus reset.");
   property p_mem_kept;
      @(posedge clk) disable iff (!rst_n) s_bus_det |=> $stable(fifo_mem[0]);
   endproperty
   a_mem_kept: assert property (p_mem_kept) else $error("FIFO storage changed by bus reset.");
   property p_clock_kept;
      @(posedge clk) disable iff (!rst_n) s_bus_det |=> $stable(pcc_reg) && $stable(synth_reg)
         && $stable(mode0_reg) && $stable(mode1_reg);
   endproperty
   a_clock_kept: assert property (p_clock_kept) else $error("Clock register hit by bus reset.");
   property p_se0_len;
      @(posedge clk) disable iff (!rst_n) bus_det |-> $past(se0, 1) && se0_cnt_reg == SE0_LAST;
   endproperty
   a_se0_len: assert property (p_se0_len) else $error("Bus reset seen before SE0 time.");
   property p_irq;
      @(posedge clk) disable iff (!rst_n) s_bus_det |=> usb_func_irq && usb_bus_reset;
   endproperty
   a_irq: assert property (p_irq) else $error("No function interrupt on bus reset.");
endmodule
`default_nettype wire

// ===== verif/usb_host_model.sv
// Model of the upstream host or hub that drives D+ and D- toward the block.
// Assumes the bench clock; the lines idle in the J state between resets.
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
   input wire logic clk,
   output logic dp,
   output logic dm
);
   initial begin
      dp = 1'b1;
      dm = 1'b0;
   end
   // Holds single-ended zero for n cycles, then returns to idle.
   task automatic se0(input int n);
      @(posedge clk);
      dp <= 1'b0;
      dm <= 1'b0;
      repeat (n) @(posedge clk);
      dp <= 1'b1;
      dm <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== verif/usb_reset_scope_control_tb_top.sv
// Self-checking bench for the USB reset scope control block.
// Assumes the APB master here and the host model on D+/D-.
`timescale 1ns/1ps
`default_nettype none
`include "usb_reset_scope_regs.svh"
module usb_reset_scope_control_tb_top;
   import usb_reset_scope_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic undef_opcode = 1'b0;
   wire logic dp;
   wire logic dm;
   apb_req_t apb_req = '0;
   apb_rsp_t apb_rsp;
   logic usb_func_irq;
   logic usb_bus_reset;
   int error_cnt = 0;
   int cmp_count = 0;
   int irq_cnt = 0;
   int brst_cnt = 0;
   logic [31:0] rd;
   logic err;
   always #25 clk = ~clk;
   always @(posedge clk) begin
      if (usb_func_irq === 1'b1) irq_cnt++;
      if (usb_bus_reset === 1'b1) brst_cnt++;
   end
   usb_host_model host (.clk(clk), .dp(dp), .dm(dm));
   usb_reset_scope_control #(.FIFO_DEPTH(8)) uut (.clk(clk), .rst_n(rst_n), .ce(ce),
      .undef_opcode(undef_opcode), .dp_pin(dp), .dm_pin(dm), .apb_req(apb_req),
      .apb_rsp(apb_rsp), .usb_func_irq(usb_func_irq), .usb_bus_reset(usb_bus_reset));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
         error_cnt++;
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      apb_req.psel <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite <= w;
      apb_req.paddr <= a;
      apb_req.pwdata <= d;
      @(posedge clk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (apb_rsp.pready !== 1'b1);
      chk(n, 2, "pready latency");
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string m);
      apb(1'b0, a, 32'h0);
      chk(rd, e, m);
   endtask
   task automatic conclude();
      $display("errors %0d comparisons %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic t_reset();
      rdchk(`PCC_OFS, 32'h0, "clock ctrl");
      rdchk(`SYNTH_OFS, 32'h0, "synth");
      rdchk(12'h304, 32'h0, "irq two");
      rdchk(`CORE_LAST_OFS, 32'h1, "fifo status");
      rdchk(12'h100, 32'h0, "unmapped data");
      chk({31'h0, err}, 32'h1, "unmapped error");
   endtask
   task automatic t_bus_reset();
      apb(1'b1, `PCC_OFS, 32'h90);
      apb(1'b1, `SYNTH_OFS, 32'h5A);
      apb(1'b1, `MODE0_OFS, 32'h3);
      apb(1'b1, `MODE1_OFS, 32'h1);
      apb(1'b1, `CORE_BASE_OFS, 32'hA5);
      apb(1'b1, 12'h338, 32'h1234);
      rdchk(`CORE_LAST_OFS, 32'h100, "one word queued");
      host.se0(60);
      repeat (6) @(posedge clk);
      chk(irq_cnt, 1, "irq pulses");
      chk(brst_cnt, 1, "bus reset pulses");
      rdchk(12'h304, 32'h20, "event flag");
      rdchk(`CORE_BASE_OFS, 32'h0, "core reg");
      rdchk(`CORE_LAST_OFS, 32'h1, "fifo empty");
      rdchk(12'h338, 32'h1234, "storage word kept");
      rdchk(`PCC_OFS, 32'h90, "clock ctrl kept");
      rdchk(`SYNTH_OFS, 32'h5A, "synth kept");
      rdchk(`MODE0_OFS, 32'h3, "mode zero kept");
      rdchk(`MODE1_OFS, 32'h1, "mode one kept");
   endtask
   task automatic t_short_se0();
      host.se0(49);
      repeat (6) @(posedge clk);
      chk(irq_cnt, 1, "short zero ignored");
   endtask
   task automatic t_undef();
      @(posedge clk);
      undef_opcode <= 1'b1;
      @(posedge clk);
      undef_opcode <= 1'b0;
      rdchk(`PCC_OFS, 32'h0, "opcode clears ctrl");
      rdchk(`MODE0_OFS, 32'h0, "opcode clears mode");
      rdchk(12'h304, 32'h0, "opcode clears flag");
   endtask
   task automatic t_both();
      apb(1'b1, `PCC_OFS, 32'h80);
      fork
         host.se0(60);
         begin
            repeat (40) @(posedge clk);
            rst_n <= 1'b0;
            repeat (25) @(posedge clk);
            rst_n <= 1'b1;
         end
      join
      repeat (6) @(posedge clk);
      chk(irq_cnt, 1, "no irq under reset");
      rdchk(12'h304, 32'h0, "flag stays clear");
      rdchk(`PCC_OFS, 32'h0, "ctrl reset");
      // Opcode reset lands in the very cycle the bus reset is detected.
      apb(1'b1, `PCC_OFS, 32'h80);
      fork
         host.se0(60);
         begin
            repeat (52) @(posedge clk);
            undef_opcode <= 1'b1;
            @(posedge clk);
            undef_opcode <= 1'b0;
         end
      join
      repeat (6) @(posedge clk);
      chk(irq_cnt, 1, "no irq when opcode reset meets bus reset");
      chk(brst_cnt, 1, "no bus reset pulse under opcode reset");
      rdchk(12'h304, 32'h0, "flag cleared by opcode reset");
      rdchk(`PCC_OFS, 32'h0, "ctrl cleared by opcode reset");
   endtask
   initial begin
      #(4000 * 50);
      error_cnt++;
      conclude();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_bus_reset();
      t_short_se0();
      t_undef();
      t_both();
      conclude();
   end
endmodule
`default_nettype wire
